// [rtl/ims_pkg.sv]
// Constants for the ISA master cycle sequencer
package ims_pkg;

  // All timing figures are in link clock periods (T)
  localparam logic [4:0] LA_SETUP_T    = 5'h05;
  localparam logic [4:0] ALE_WIDTH_T   = 5'h01;
  localparam logic [4:0] ALE_TO_CMD_T  = 5'h02;
  localparam logic [4:0] LA_AFTER_CMD_T = 5'h0D;
  localparam logic [4:0] SA_AFTER_CMD_T = 5'h0A;
  localparam logic [4:0] IO_SPACING_T  = 5'h0C;
  localparam logic [4:0] CMD_SHORT_T   = 5'h05;
  localparam logic [4:0] CMD_STD_T     = 5'h09;
  localparam logic [4:0] CMD_LONG16_T  = 5'h0D;
  localparam logic [4:0] CMD_EXT8_T    = 5'h19;

  // Wait-state setting codes
  localparam logic [1:0] WAIT_SHORT = 2'h0;
  localparam logic [1:0] WAIT_STD   = 2'h1;
  localparam logic [1:0] WAIT_LONG  = 2'h2;

  // Address layout
  localparam int LA_MSB    = 23;
  localparam int LA_LSB    = 17;
  localparam int SA_MSB    = 19;
  localparam logic [3:0] LOW_MEG_TOP = 4'h0;

  typedef enum logic [2:0] {
    IMS_IDLE  = 3'b000,
    IMS_SETUP = 3'b001,
    IMS_ALE   = 3'b011,
    IMS_GAP   = 3'b010,
    IMS_CMD   = 3'b110,
    IMS_HOLD  = 3'b111
  } ims_state_t;

endpackage

// [rtl/ims_isa_master_cycle_sequencer.sv]
// ISA master cycle sequencer: request handshake and link-clock strobe timing
`timescale 1ns/100ps
module ims_isa_master_cycle_sequencer
  import ims_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        isa_double_rate_clock,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic        req_write_in,
  input  wire logic        req_io_in,
  input  wire logic        req_wide_in,
  input  wire logic [1:0]  req_wait_in,
  input  wire logic [23:0] req_addr_in,
  input  wire logic [15:0] req_data_in,
  output logic             done_out,
  output logic [15:0]      rd_data_out,
  output logic [6:0]       la_out,
  output logic [19:0]      sa_out,
  output logic             sbhe_n_out,
  output logic             ale_n_out,
  output logic             memr_n_out,
  output logic             memw_n_out,
  output logic             smemr_n_out,
  output logic             smemw_n_out,
  output logic             ior_n_out,
  output logic             iow_n_out,
  input  wire logic [15:0] sd_in,
  output logic [15:0]      sd_out,
  output logic             sd_oe_out
);

  // Command width in link clocks for the chosen slave width, space and wait setting
  function automatic logic [4:0] cmd_width(input logic io, input logic wide,
                                           input logic [1:0] wsel);
    logic [4:0] w;
    w = CMD_STD_T;
    if (wsel == WAIT_SHORT) begin
      w = CMD_SHORT_T;
    end else if (wsel == WAIT_LONG) begin
      if (io || wide) begin
        w = CMD_LONG16_T;
      end else begin
        w = CMD_EXT8_T;
      end
    end
    return w;
  endfunction

  // ---------------- System clock side ----------------
  logic        busy_reg,    busy_next;
  logic        req_tgl_reg, req_tgl_next;
  logic        h_write_reg, h_write_next;
  logic        h_io_reg,    h_io_next;
  logic        h_wide_reg,  h_wide_next;
  logic [1:0]  h_wait_reg,  h_wait_next;
  logic [23:0] h_addr_reg,  h_addr_next;
  logic [15:0] h_data_reg,  h_data_next;
  logic        done_reg,    done_next;
  logic [15:0] rd_reg,      rd_next;
  logic        ak1_reg, ak2_reg, ak3_reg;
  logic        ack_seen_reg, ack_seen_next;
  logic        ack_tgl_reg;
  logic [15:0] rd_word_reg;
  logic        ack_event;

  assign req_ready_out = !busy_reg;
  assign done_out      = done_reg;
  assign rd_data_out   = rd_reg;

  always_comb begin
    busy_next     = busy_reg;
    req_tgl_next  = req_tgl_reg;
    h_write_next  = h_write_reg;
    h_io_next     = h_io_reg;
    h_wide_next   = h_wide_reg;
    h_wait_next   = h_wait_reg;
    h_addr_next   = h_addr_reg;
    h_data_next   = h_data_reg;
    done_next     = 1'b0;
    rd_next       = rd_reg;
    ack_seen_next = ack_seen_reg;
    // Change counts only once the last two stages agree
    ack_event     = (ak2_reg == ak3_reg) && (ak3_reg != ack_seen_reg);
    if (ack_event) begin
      ack_seen_next = ak3_reg;
      busy_next     = 1'b0;
      done_next     = 1'b1;
      // Link side holds this word until the next request
      rd_next       = rd_word_reg;
    end
    if (req_valid_in && !busy_reg) begin
      busy_next    = 1'b1;
      req_tgl_next = !req_tgl_reg;
      h_write_next = req_write_in;
      h_io_next    = req_io_in;
      h_wide_next  = req_wide_in;
      h_wait_next  = req_wait_in;
      h_addr_next  = req_addr_in;
      h_data_next  = req_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      busy_reg     <= 1'b0;
      req_tgl_reg  <= 1'b0;
      h_write_reg  <= 1'b0;
      h_io_reg     <= 1'b0;
      h_wide_reg   <= 1'b0;
      h_wait_reg   <= WAIT_STD;
      h_addr_reg   <= 24'h000000;
      h_data_reg   <= 16'h0000;
      done_reg     <= 1'b0;
      rd_reg       <= 16'h0000;
      ak1_reg      <= 1'b0;
      ak2_reg      <= 1'b0;
      ak3_reg      <= 1'b0;
      ack_seen_reg <= 1'b0;
    end else begin
      busy_reg     <= busy_next;
      req_tgl_reg  <= req_tgl_next;
      h_write_reg  <= h_write_next;
      h_io_reg     <= h_io_next;
      h_wide_reg   <= h_wide_next;
      h_wait_reg   <= h_wait_next;
      h_addr_reg   <= h_addr_next;
      h_data_reg   <= h_data_next;
      done_reg     <= done_next;
      rd_reg       <= rd_next;
      ak1_reg      <= ack_tgl_reg;
      ak2_reg      <= ak1_reg;
      ak3_reg      <= ak2_reg;
      ack_seen_reg <= ack_seen_next;
    end
  end

  // ---------------- Link clock side ----------------
  // Reset is carried over by two stages; the link clock is expected to run during reset
  logic lr1_reg, lr2_reg;

  always_ff @(posedge isa_double_rate_clock) begin
    lr1_reg <= rst_in;
    lr2_reg <= lr1_reg;
  end

  ims_state_t  state_reg, state_next;
  logic [4:0]  cnt_reg,   cnt_next;
  logic [4:0]  width_reg, width_next;
  logic        l_write_reg, l_write_next;
  logic        l_io_reg,    l_io_next;
  logic        l_low_reg,   l_low_next;
  logic        l_wide_reg,  l_wide_next;
  logic [23:0] l_addr_reg,  l_addr_next;
  logic [15:0] l_data_reg,  l_data_next;
  logic        rq1_reg, rq2_reg, rq3_reg;
  logic        req_seen_reg, req_seen_next;
  logic        ack_tgl_next;
  logic [15:0] rd_word_next;
  logic        req_event;
  logic [6:0]  la_reg,    la_next;
  logic [19:0] sa_reg,    sa_next;
  logic        sbhe_n_reg, sbhe_n_next;
  logic        ale_n_reg,  ale_n_next;
  logic        memr_n_reg, memr_n_next;
  logic        memw_n_reg, memw_n_next;
  logic        smemr_n_reg, smemr_n_next;
  logic        smemw_n_reg, smemw_n_next;
  logic        ior_n_reg,  ior_n_next;
  logic        iow_n_reg,  iow_n_next;
  logic [15:0] sd_reg,     sd_next;
  logic        sd_oe_reg,  sd_oe_next;
  logic        cmd_on;

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg + 5'h01;
    width_next    = width_reg;
    l_write_next  = l_write_reg;
    l_io_next     = l_io_reg;
    l_low_next    = l_low_reg;
    l_wide_next   = l_wide_reg;
    l_addr_next   = l_addr_reg;
    l_data_next   = l_data_reg;
    req_seen_next = req_seen_reg;
    ack_tgl_next  = ack_tgl_reg;
    rd_word_next  = rd_word_reg;
    req_event     = (rq2_reg == rq3_reg) && (rq3_reg != req_seen_reg);
    unique case (state_reg)
      IMS_IDLE: begin
        cnt_next = 5'h00;
        if (req_event) begin
          // Held words are stable: the system side stays busy until acknowledged
          req_seen_next = rq3_reg;
          l_write_next  = h_write_reg;
          l_io_next     = h_io_reg;
          l_wide_next   = h_wide_reg;
          l_addr_next   = h_addr_reg;
          l_data_next   = h_data_reg;
          l_low_next    = (h_addr_reg[23:20] == LOW_MEG_TOP);
          width_next    = cmd_width(h_io_reg, h_wide_reg, h_wait_reg);
          state_next    = IMS_SETUP;
        end
      end
      IMS_SETUP: begin
        // Upper address settles before the strobe; also the gap after the last command
        if (cnt_reg == LA_SETUP_T - 5'h01) begin
          cnt_next   = 5'h00;
          state_next = IMS_ALE;
        end
      end
      IMS_ALE: begin
        if (cnt_reg == ALE_WIDTH_T - 5'h01) begin
          cnt_next   = 5'h00;
          state_next = IMS_GAP;
        end
      end
      IMS_GAP: begin
        // Counter restarts at strobe release, so the strobe width is taken off and the command waits two clocks
        if (cnt_reg == ALE_TO_CMD_T - ALE_WIDTH_T - 5'h01) begin
          cnt_next   = 5'h00;
          state_next = IMS_CMD;
        end
      end
      IMS_CMD: begin
        if (cnt_reg == width_reg - 5'h01) begin
          rd_word_next = sd_in;
          state_next   = IMS_HOLD;
        end
      end
      IMS_HOLD: begin
        // Addresses stay put until the longer of the two hold counts is met
        if (cnt_reg >= LA_AFTER_CMD_T - 5'h01 &&
            cnt_reg >= SA_AFTER_CMD_T - 5'h01) begin
          ack_tgl_next = !ack_tgl_reg;
          cnt_next     = 5'h00;
          state_next   = IMS_IDLE;
        end
      end
      default: begin
        cnt_next   = 5'h00;
        state_next = IMS_IDLE;
      end
    endcase
  end

  // Pins follow the next state so they come straight from flip-flops
  always_comb begin
    cmd_on       = (state_next == IMS_CMD);
    la_next      = la_reg;
    sa_next      = sa_reg;
    sbhe_n_next  = sbhe_n_reg;
    if (state_next == IMS_SETUP && state_reg == IMS_IDLE) begin
      la_next     = l_addr_next[LA_MSB:LA_LSB];
      sa_next     = l_addr_next[SA_MSB:0];
      sbhe_n_next = !(l_wide_next || l_addr_next[0]);
    end
    ale_n_next   = !(state_next == IMS_ALE);
    memr_n_next  = !(cmd_on && !l_io_next && !l_write_next);
    memw_n_next  = !(cmd_on && !l_io_next && l_write_next);
    smemr_n_next = !(cmd_on && !l_io_next && l_low_next && !l_write_next);
    smemw_n_next = !(cmd_on && !l_io_next && l_low_next && l_write_next);
    // I/O spacing follows from setup, strobe and hold, far above twelve clocks
    ior_n_next   = !(cmd_on && l_io_next && !l_write_next);
    iow_n_next   = !(cmd_on && l_io_next && l_write_next);
    sd_oe_next   = cmd_on && l_write_next;
    sd_next      = l_data_next;
  end

  always_ff @(posedge isa_double_rate_clock) begin
    if (lr2_reg) begin
      state_reg    <= IMS_IDLE;
      cnt_reg      <= 5'h00;
      width_reg    <= CMD_STD_T;
      l_write_reg  <= 1'b0;
      l_io_reg     <= 1'b0;
      l_low_reg    <= 1'b0;
      l_wide_reg   <= 1'b0;
      l_addr_reg   <= 24'h000000;
      l_data_reg   <= 16'h0000;
      rq1_reg      <= 1'b0;
      rq2_reg      <= 1'b0;
      rq3_reg      <= 1'b0;
      req_seen_reg <= 1'b0;
      ack_tgl_reg  <= 1'b0;
      rd_word_reg  <= 16'h0000;
      la_reg       <= 7'h00;
      sa_reg       <= 20'h00000;
      sbhe_n_reg   <= 1'b1;
      ale_n_reg    <= 1'b1;
      memr_n_reg   <= 1'b1;
      memw_n_reg   <= 1'b1;
      smemr_n_reg  <= 1'b1;
      smemw_n_reg  <= 1'b1;
      ior_n_reg    <= 1'b1;
      iow_n_reg    <= 1'b1;
      sd_reg       <= 16'h0000;
      sd_oe_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      width_reg    <= width_next;
      l_write_reg  <= l_write_next;
      l_io_reg     <= l_io_next;
      l_low_reg    <= l_low_next;
      l_wide_reg   <= l_wide_next;
      l_addr_reg   <= l_addr_next;
      l_data_reg   <= l_data_next;
      rq1_reg      <= req_tgl_reg;
      rq2_reg      <= rq1_reg;
      rq3_reg      <= rq2_reg;
      req_seen_reg <= req_seen_next;
      ack_tgl_reg  <= ack_tgl_next;
      rd_word_reg  <= rd_word_next;
      la_reg       <= la_next;
      sa_reg       <= sa_next;
      sbhe_n_reg   <= sbhe_n_next;
      ale_n_reg    <= ale_n_next;
      memr_n_reg   <= memr_n_next;
      memw_n_reg   <= memw_n_next;
      smemr_n_reg  <= smemr_n_next;
      smemw_n_reg  <= smemw_n_next;
      ior_n_reg    <= ior_n_next;
      iow_n_reg    <= iow_n_next;
      sd_reg       <= sd_next;
      sd_oe_reg    <= sd_oe_next;
    end
  end

  assign la_out      = la_reg;
  assign sa_out      = sa_reg;
  assign sbhe_n_out  = sbhe_n_reg;
  assign ale_n_out   = ale_n_reg;
  assign memr_n_out  = memr_n_reg;
  assign memw_n_out  = memw_n_reg;
  assign smemr_n_out = smemr_n_reg;
  assign smemw_n_out = smemw_n_reg;
  assign ior_n_out   = ior_n_reg;
  assign iow_n_out   = iow_n_reg;
  assign sd_out      = sd_reg;
  assign sd_oe_out   = sd_oe_reg;

endmodule

// [testbench/ims_seq_props.sv]
// Link-side strobe and address timing checker for the cycle sequencer
`timescale 1ns/100ps
module ims_seq_props (
  input wire logic        rst_in,
  input wire logic        isa_double_rate_clock,
  input wire logic [6:0]  la_out,
  input wire logic [19:0] sa_out,
  input wire logic        sbhe_n_out,
  input wire logic        ale_n_out,
  input wire logic        memr_n_out,
  input wire logic        memw_n_out,
  input wire logic        smemr_n_out,
  input wire logic        smemw_n_out,
  input wire logic        ior_n_out,
  input wire logic        iow_n_out
);
  logic        mem_w;
  logic        io_w;
  logic        idle_w;
  logic [7:0]  la_age_w;
  logic [7:0]  sa_age_w;
  logic [7:0]  la_age_reg;
  logic [7:0]  sa_age_reg;
  logic [7:0]  low_reg;
  logic [7:0]  gap_reg;
  logic        io_q_reg;
  logic [6:0]  la_q_reg;
  logic [20:0] sa_q_reg;
  logic [3:0]  rst_sr_reg;
  logic        chk_off_w;
  assign mem_w = !(memr_n_out && memw_n_out && smemr_n_out && smemw_n_out);
  assign io_w = !(ior_n_out && iow_n_out);
  assign idle_w = !mem_w && !io_w;
  // Link side leaves reset a few of its clocks after the pin; pins are unknown until then
  assign chk_off_w = rst_in || (|rst_sr_reg);
  // Samples since the pins last moved, saturating so long idles never wrap
  assign la_age_w = (la_out != la_q_reg) ? 8'h00 : la_age_reg + {7'h00, la_age_reg != 8'hFF};
  assign sa_age_w = ({sbhe_n_out, sa_out} != sa_q_reg) ? 8'h00
                  : sa_age_reg + {7'h00, sa_age_reg != 8'hFF};
  always_ff @(posedge isa_double_rate_clock) begin
    if (chk_off_w) begin
      la_age_reg <= 8'hFF;
      sa_age_reg <= 8'hFF;
      low_reg    <= 8'h00;
      gap_reg    <= 8'hFF;
    end else begin
      la_age_reg <= la_age_w;
      sa_age_reg <= sa_age_w;
      low_reg    <= idle_w ? 8'h00 : low_reg + 8'h01;
      gap_reg    <= (io_w && !io_q_reg) ? 8'h01 : gap_reg + {7'h00, gap_reg != 8'hFF};
    end
    la_q_reg <= la_out;
    sa_q_reg <= {sbhe_n_out, sa_out};
    io_q_reg <= io_w;
    rst_sr_reg <= {rst_sr_reg[2:0], rst_in};
  end
  default clocking cb @(posedge isa_double_rate_clock); endclocking
  default disable iff (chk_off_w);
  property p_la_ale; $rose(ale_n_out) |-> la_age_w >= 8'h05; endproperty
  a_la_ale: assert property (p_la_ale) else $error("upper address late at strobe end");
  property p_la_mem; $rose(mem_w) |-> la_age_w >= 8'h05; endproperty
  a_la_mem: assert property (p_la_mem) else $error("upper address late at command");
  property p_sa_ale; $rose(ale_n_out) |-> sa_age_w >= 8'h01; endproperty
  a_sa_ale: assert property (p_sa_ale) else $error("system address late at strobe end");
  property p_sa_cmd; $fell(idle_w) |-> sa_age_w >= 8'h02; endproperty
  a_sa_cmd: assert property (p_sa_cmd) else $error("system address late at command");
  property p_ale_wid; $fell(ale_n_out) |=> ale_n_out; endproperty
  a_ale_wid: assert property (p_ale_wid) else $error("address strobe width wrong");
  property p_ale_cmd; $fell(ale_n_out) |-> idle_w [*2]; endproperty
  a_ale_cmd: assert property (p_ale_cmd) else $error("command too soon after strobe");
  property p_la_hold; $fell(ale_n_out) |-> ##14 la_age_w >= 8'h13; endproperty
  a_la_hold: assert property (p_la_hold) else $error("upper address dropped early");
  property p_la_neg; $rose(ale_n_out) |-> ##13 la_age_w >= 8'h13; endproperty
  a_la_neg: assert property (p_la_neg) else $error("upper address dropped after strobe");
  property p_la_cmd; $rose(mem_w) |-> ##12 la_age_w >= 8'h13; endproperty
  a_la_cmd: assert property (p_la_cmd) else $error("upper address dropped after command");
  property p_cmd_wid; $rose(idle_w) |-> low_reg inside {8'h05, 8'h09, 8'h0D, 8'h19}; endproperty
  a_cmd_wid: assert property (p_cmd_wid) else $error("command width not a legal length");
  property p_sa_hold; $rose(mem_w) |-> ##9 sa_age_w >= 8'h10; endproperty
  a_sa_hold: assert property (p_sa_hold) else $error("system address dropped early");
  property p_cmd_ale; $fell(ale_n_out) |-> $past(idle_w); endproperty
  a_cmd_ale: assert property (p_cmd_ale) else $error("command still low at strobe");
  property p_io_gap; $rose(io_w) |-> gap_reg >= 8'h0C; endproperty
  a_io_gap: assert property (p_io_gap) else $error("I/O commands too close");
endmodule

bind ims_isa_master_cycle_sequencer ims_seq_props ims_seq_props_inst (
  .rst_in(rst_in), .isa_double_rate_clock(isa_double_rate_clock), .la_out(la_out),
  .sa_out(sa_out), .sbhe_n_out(sbhe_n_out), .ale_n_out(ale_n_out), .memr_n_out(memr_n_out),
  .memw_n_out(memw_n_out), .smemr_n_out(smemr_n_out), .smemw_n_out(smemw_n_out),
  .ior_n_out(ior_n_out), .iow_n_out(iow_n_out)
);

// [testbench/ims_slave_model.sv]
// Memory and I/O slave card answering the command strobes
`timescale 1ns/100ps
module ims_slave_model (
  input  wire logic        link_clk_in,
  input  wire logic [6:0]  la_in,
  input  wire logic [19:0] sa_in,
  input  wire logic        memr_n_in,
  input  wire logic        memw_n_in,
  input  wire logic        ior_n_in,
  input  wire logic        iow_n_in,
  input  wire logic [15:0] sd_wr_in,
  output logic      [15:0] sd_rd_out
);
  logic [15:0] mem [int];
  logic [15:0] drv_reg = 16'h5A5A;
  int          key;
  assign sd_rd_out = drv_reg;
  always @(posedge link_clk_in) begin
    key = {!(ior_n_in && iow_n_in), la_in, sa_in};
    if (!memw_n_in || !iow_n_in)
      mem[key] = sd_wr_in;
    // Unwritten places float to the pull-ups; released bus toggles
    if (!memr_n_in || !ior_n_in)
      drv_reg <= mem.exists(key) ? mem[key] : 16'hFFFF;
    else
      drv_reg <= ~drv_reg;
  end
endmodule

// [testbench/ims_isa_master_cycle_sequencer_test.sv]
// Self-checking bench for the ISA master cycle sequencer
`timescale 1ns/100ps
module ims_isa_master_cycle_sequencer_test;
  logic        clock_in = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_in = 1'b1;
  logic        req_valid_in = 1'b0, req_write_in = 1'b0, req_io_in = 1'b0, req_wide_in = 1'b0;
  logic [1:0]  req_wait_in = 2'h0;
  logic [23:0] req_addr_in = 24'h000000;
  logic [15:0] req_data_in = 16'h0000;
  logic        req_ready_out, done_out, sbhe_n_out, ale_n_out, sd_oe_out;
  logic        memr_n_out, memw_n_out, smemr_n_out, smemw_n_out, ior_n_out, iow_n_out;
  logic [15:0] rd_data_out, sd_in, sd_out, d;
  logic [6:0]  la_out, la_c;
  logic [19:0] sa_out, sa_c;
  logic [5:0]  st;
  logic        hb_c, oe_c, a_prev = 1'b1, i_prev = 1'b1;
  logic [31:0] r;
  logic [23:0] a;
  logic [15:0] mdl [int];
  int          tk = 0, t_ale = 0, t_cmd = 0, t_end = 0, ale_cnt = 0, failures = 0, checks_done = 0;
  wire logic   idle_w = &{memr_n_out, memw_n_out, smemr_n_out, smemw_n_out, ior_n_out, iow_n_out};
  initial begin
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    #3.7;
    forever #62.5 link_clk = ~link_clk;
  end
  ims_isa_master_cycle_sequencer ims_isa_master_cycle_sequencer_inst (
    .clock_in(clock_in), .rst_in(rst_in), .isa_double_rate_clock(link_clk),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_write_in(req_write_in),
    .req_io_in(req_io_in), .req_wide_in(req_wide_in), .req_wait_in(req_wait_in),
    .req_addr_in(req_addr_in), .req_data_in(req_data_in), .done_out(done_out),
    .rd_data_out(rd_data_out), .la_out(la_out), .sa_out(sa_out), .sbhe_n_out(sbhe_n_out),
    .ale_n_out(ale_n_out), .memr_n_out(memr_n_out), .memw_n_out(memw_n_out),
    .smemr_n_out(smemr_n_out), .smemw_n_out(smemw_n_out), .ior_n_out(ior_n_out),
    .iow_n_out(iow_n_out), .sd_in(sd_in), .sd_out(sd_out), .sd_oe_out(sd_oe_out));
  ims_slave_model ims_slave_model_inst (
    .link_clk_in(link_clk), .la_in(la_out), .sa_in(sa_out), .memr_n_in(memr_n_out),
    .memw_n_in(memw_n_out), .ior_n_in(ior_n_out), .iow_n_in(iow_n_out), .sd_wr_in(sd_out),
    .sd_rd_out(sd_in));
  // Pins looked at half a link period after they move
  always @(negedge link_clk) begin
    tk++;
    if (a_prev && !ale_n_out) begin
      t_ale = tk;
      ale_cnt++;
    end
    if (i_prev && !idle_w) begin
      t_cmd = tk;
      st = {memr_n_out, memw_n_out, smemr_n_out, smemw_n_out, ior_n_out, iow_n_out};
      {la_c, sa_c, hb_c, oe_c} = {la_out, sa_out, sbhe_n_out, sd_oe_out};
    end
    if (!i_prev && idle_w)
      t_end = tk;
    a_prev = ale_n_out;
    i_prev = idle_w;
  end
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp_vec(input logic [27:0] got, input logic [27:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    checks_done++;
    if (got != exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_sig(input bit on_done, input int lim);
    int n;
    n = 0;
    while ((on_done ? done_out : req_ready_out) !== 1'b1 && n < lim) begin
      @(negedge clock_in);
      n++;
    end
    if ((on_done ? done_out : req_ready_out) !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask
  task automatic xfer(input logic wr, io, wide, input logic [1:0] wt, input logic [23:0] ad,
                      input logic [15:0] dt);
    int base;
    int w;
    int k;
    logic [5:0] es;
    base = ale_cnt;
    k = {io, ad[23:17], ad[19:0]};
    w = (wt == 2'h0) ? 5 : (wt == 2'h2) ? ((wide || io) ? 13 : 25) : 9;
    es = 6'h3F;
    if (io)
      es[wr ? 0 : 1] = 1'b0;
    else begin
      es[wr ? 4 : 5] = 1'b0;
      if (ad[23:20] == 4'h0)
        es[wr ? 2 : 3] = 1'b0;
    end
    @(negedge clock_in);
    {req_valid_in, req_write_in, req_io_in, req_wide_in, req_wait_in} = {1'b1, wr, io, wide, wt};
    {req_addr_in, req_data_in} = {ad, dt};
    wait_sig(1'b0, 100);
    @(negedge clock_in);
    // Content offered while busy must be ignored
    if (req_ready_out === 1'b0) begin
      {req_addr_in, req_write_in} = {~ad, ~wr};
      repeat (4) @(negedge clock_in);
    end
    req_valid_in = 1'b0;
    wait_sig(1'b1, 3000);
    cmp_cnt(ale_cnt - base, 1);
    cmp_vec(st, es);
    cmp_vec({la_c, sa_c, hb_c}, {ad[23:17], ad[19:0], !(wide || ad[0])});
    cmp_cnt(t_cmd - t_ale, 2);
    cmp_cnt(t_end - t_cmd, w);
    cmp_cnt(t_end - t_ale, w + 2);
    cmp_vec(oe_c, wr);
    if (wr)
      mdl[k] = dt;
    else
      cmp_vec(rd_data_out, mdl.exists(k) ? mdl[k] : 16'hFFFF);
  endtask
  initial begin
    void'($urandom(90));
    // Link side copies reset over two of its clocks; the idle gap below covers that
    repeat (10) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (30) @(negedge clock_in);
    for (int c = 0; c < 16; c++) begin
      r = $urandom;
      a = r[23:0];
      a[23:20] = (c[1] ^ c[2]) ? 4'h0 : (a[23:20] | 4'h1);
      r = $urandom;
      d = r[15:0];
      xfer(1'b1, c[0], c[1], c[3:2], a, d);
      xfer(1'b0, c[0], c[1], c[3:2], a, d);
    end
    for (int c = 0; c < 6; c++) begin
      r = $urandom;
      xfer(r[0], r[1], r[2], r[4:3], {r[31:20], r[11:0]}, r[27:12]);
    end
    conclude();
  end
endmodule
